// >>> core/mps_cfg.svh
// Function
// - Select code 1 puts the branch latch on the address outputs.
// - Select code 3 passes the direct inputs to the address outputs.
// - Select code 2 outputs stack top; file enable high leaves stack untouched.
// - Select code 0 outputs counter; counter loads output plus carry-in every edge.
// - Output enable low only raises the oe output, never floats the address; zero forces low; else OR forces high.
// - File enable low, push high: pointer up, counter written to new top.
// - File enable low, push low: pointer down, second entry becomes top.
// - Stack is circular; pop clears nothing, whatever source is selected.
// - Push during a jump stores the old counter, not the jump target.
// - Return outputs top, loads counter with top plus carry-in, pops same edge.
// - Stack top is the entry the pointer addresses; reads there, push writes the entry above.
// - Reading top while pushing outputs old top, then old counter on top.
// - Edge ending a call pushes call address plus one as return address.
// - A call followed at once by a return works correctly.
// - Carry-in low makes the counter reload the same address.
// - Branch latch loads on the edge only while its enable is low.
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH

`define MPS_ADDR_W      4
`define MPS_STACK_DEPTH 4
`define MPS_SYNC_STAGES 2

`define MPS_SEL_UPC     2'h0
`define MPS_SEL_LATCH   2'h1
`define MPS_SEL_STACK   2'h2
`define MPS_SEL_DIRECT  2'h3

`define MPS_ADDR_RST    1'b0
`define MPS_SYNC_RST    1'b1
`define MPS_FLAG_RST    1'b0

`endif

// >>> core/mps_pkg.sv
`include "mps_cfg.svh"

package mps_pkg;

    typedef enum logic [1:0] {
        MPS_SRC_UPC    = `MPS_SEL_UPC,
        MPS_SRC_LATCH  = `MPS_SEL_LATCH,
        MPS_SRC_STACK  = `MPS_SEL_STACK,
        MPS_SRC_DIRECT = `MPS_SEL_DIRECT
    } mps_src_t;

    typedef enum logic [1:0] {
        MPS_STK_HOLD = 2'h0,
        MPS_STK_PUSH = 2'h1,
        MPS_STK_POP  = 2'h2
    } mps_stk_op_t;

endpackage

// >>> core/mps_stack.sv
`timescale 1ns/1ps
`default_nettype none
`include "mps_cfg.svh"

module mps_stack #(
    parameter int WIDTH = `MPS_ADDR_W,
    parameter int DEPTH = `MPS_STACK_DEPTH
) (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire mps_pkg::mps_stk_op_t  op_i,
    input  wire logic [WIDTH-1:0]      push_data_i,
    output logic      [WIDTH-1:0]      stack_top_entry_o
);
    import mps_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [PW-1:0]    stack_pointer_reg;
    logic [PW-1:0]    stack_pointer_next;
    logic [WIDTH-1:0] file_q [DEPTH];

    // Pointer wraps, so the file behaves as a ring
    always_comb begin
        stack_pointer_next = stack_pointer_reg;
        unique case (op_i)
            MPS_STK_PUSH: stack_pointer_next = stack_pointer_reg + 1'b1;
            MPS_STK_POP:  stack_pointer_next = stack_pointer_reg - 1'b1;
            default:      stack_pointer_next = stack_pointer_reg;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stack_pointer_reg <= {PW{`MPS_ADDR_RST}};
        end else begin
            stack_pointer_reg <= stack_pointer_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            logic [WIDTH-1:0] entry_reg;
            logic [WIDTH-1:0] entry_next;

            // Only the entry the new pointer lands on is written; pops
            // leave data in place
            always_comb begin
                entry_next = entry_reg;
                if (op_i == MPS_STK_PUSH &&
                    stack_pointer_next == PW'(i)) begin
                    entry_next = push_data_i;
                end
            end

            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    entry_reg <= {WIDTH{`MPS_ADDR_RST}};
                end else begin
                    entry_reg <= entry_next;
                end
            end

            assign file_q[i] = entry_reg;
        end
    endgenerate

    assign stack_top_entry_o = file_q[stack_pointer_reg];

endmodule

`default_nettype wire

// >>> core/mps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mps_cfg.svh"

module mps_sequencer #(
    parameter int ADDR_W = `MPS_ADDR_W,
    parameter int DEPTH  = `MPS_STACK_DEPTH
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              source_select_hi_i,
    input  wire logic              source_select_lo_i,
    input  wire logic              file_enable_n_i,
    input  wire logic              push_not_pop_i,
    input  wire logic              incrementer_carry_in_i,
    input  wire logic              latch_load_enable_n_i,
    input  wire logic              force_zero_n_i,
    input  wire logic              output_enable_n_i,
    input  wire logic [ADDR_W-1:0] force_one_i,
    input  wire logic [ADDR_W-1:0] direct_addr_i,
    input  wire logic [ADDR_W-1:0] branch_latch_data_i,
    output logic      [ADDR_W-1:0] next_addr_o,
    output logic                   next_addr_oe_o,
    output logic                   incrementer_carry_out_o
);
    import mps_pkg::*;

    // Eight single control pins plus three address-wide groups
    localparam int CTRL_W = 8;
    localparam int IN_W   = CTRL_W + 3 * ADDR_W;

    // Pin synchroniser: every pin passes two flip-flops
    logic [IN_W-1:0] pins_raw;
    logic [IN_W-1:0] sync1_reg;
    logic [IN_W-1:0] sync1_next;
    logic [IN_W-1:0] sync2_reg;
    logic [IN_W-1:0] sync2_next;

    assign pins_raw = {source_select_hi_i,
                       source_select_lo_i,
                       file_enable_n_i,
                       push_not_pop_i,
                       incrementer_carry_in_i,
                       latch_load_enable_n_i,
                       force_zero_n_i,
                       output_enable_n_i,
                       force_one_i,
                       direct_addr_i,
                       branch_latch_data_i};

    always_comb begin
        sync1_next = pins_raw;
        sync2_next = sync1_reg;
    end

    // Idle pattern at reset: enables and active-low controls inactive,
    // selects on the direct inputs and the stack held, so the first two
    // edges after release reload the counter with zero and register all ones with carry-out high at the outputs
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= {IN_W{`MPS_SYNC_RST}};
            sync2_reg <= {IN_W{`MPS_SYNC_RST}};
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // Synchronised views of the pins
    logic              sel_hi_s;
    logic              sel_lo_s;
    logic              file_enable_n_s;
    logic              push_not_pop_s;
    logic              carry_in_s;
    logic              latch_load_enable_n_s;
    logic              force_zero_n_s;
    logic              output_enable_n_s;
    logic [ADDR_W-1:0] force_one_s;
    logic [ADDR_W-1:0] direct_addr_s;
    logic [ADDR_W-1:0] latch_data_s;

    assign {sel_hi_s,
            sel_lo_s,
            file_enable_n_s,
            push_not_pop_s,
            carry_in_s,
            latch_load_enable_n_s,
            force_zero_n_s,
            output_enable_n_s,
            force_one_s,
            direct_addr_s,
            latch_data_s} = sync2_reg;

    // Internal state
    logic [ADDR_W-1:0] micro_program_counter_reg;
    logic [ADDR_W-1:0] micro_program_counter_next;
    logic [ADDR_W-1:0] branch_latch_reg;
    logic [ADDR_W-1:0] branch_latch_next;
    logic [ADDR_W-1:0] stack_top_entry;

    // Output flip-flops
    logic [ADDR_W-1:0] next_addr_reg;
    logic [ADDR_W-1:0] next_addr_next;
    logic              next_addr_oe_reg;
    logic              next_addr_oe_next;
    logic              carry_out_reg;
    logic              carry_out_next;

    // Datapath
    mps_src_t          source;
    mps_stk_op_t       stack_op;
    logic [ADDR_W-1:0] selected_addr;
    logic [ADDR_W-1:0] forced_addr;
    logic [ADDR_W:0]   inc_sum;

    always_comb begin
        source = mps_src_t'({sel_hi_s, sel_lo_s});
        unique case (source)
            MPS_SRC_UPC:    selected_addr = micro_program_counter_reg;
            MPS_SRC_LATCH:  selected_addr = branch_latch_reg;
            MPS_SRC_STACK:  selected_addr = stack_top_entry;
            MPS_SRC_DIRECT: selected_addr = direct_addr_s;
        endcase
    end

    // Zero overrides the per-bit OR; output enable acts only at the pins
    always_comb begin
        if (!force_zero_n_s) begin
            forced_addr = {ADDR_W{1'b0}};
        end else begin
            forced_addr = selected_addr | force_one_s;
        end
    end

    // Incrementer: adds carry-in to the word just addressed
    always_comb begin
        inc_sum = {1'b0, forced_addr} + {{ADDR_W{1'b0}}, carry_in_s};
    end

    // Push writes the counter held before the edge, so a jump target or
    // the stack top just read never lands on the stack
    // File enable high leaves pointer and entries untouched
    always_comb begin
        if (file_enable_n_s) begin
            stack_op = MPS_STK_HOLD;
        end else if (push_not_pop_s) begin
            stack_op = MPS_STK_PUSH;
        end else begin
            stack_op = MPS_STK_POP;
        end
    end

    mps_stack #(
        .WIDTH (ADDR_W),
        .DEPTH (DEPTH)
    ) u_stack (
        .clk_i             (clk_i),
        .reset_n_i         (reset_n_i),
        .op_i              (stack_op),
        .push_data_i       (micro_program_counter_reg),
        .stack_top_entry_o (stack_top_entry)
    );

    // Counter takes the address just issued plus carry-in, whatever the
    // source, so jumps and returns continue from their target
    always_comb begin
        micro_program_counter_next = inc_sum[ADDR_W-1:0];
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            micro_program_counter_reg <= {ADDR_W{`MPS_ADDR_RST}};
        end else begin
            micro_program_counter_reg <= micro_program_counter_next;
        end
    end

    // Branch latch holds unless its load enable is low
    always_comb begin
        if (!latch_load_enable_n_s) begin
            branch_latch_next = latch_data_s;
        end else begin
            branch_latch_next = branch_latch_reg;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            branch_latch_reg <= {ADDR_W{`MPS_ADDR_RST}};
        end else begin
            branch_latch_reg <= branch_latch_next;
        end
    end

    // Outputs show the address chosen in the cycle just ended
    always_comb begin
        next_addr_next    = forced_addr;
        next_addr_oe_next = !output_enable_n_s;
        carry_out_next    = inc_sum[ADDR_W];
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            next_addr_reg    <= {ADDR_W{`MPS_ADDR_RST}};
            next_addr_oe_reg <= `MPS_FLAG_RST;
            carry_out_reg    <= `MPS_FLAG_RST;
        end else begin
            next_addr_reg    <= next_addr_next;
            next_addr_oe_reg <= next_addr_oe_next;
            carry_out_reg    <= carry_out_next;
        end
    end

    assign next_addr_o             = next_addr_reg;
    assign next_addr_oe_o          = next_addr_oe_reg;
    assign incrementer_carry_out_o = carry_out_reg;

endmodule

`default_nettype wire

// >>> bench/mps_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer_checker #(
    parameter int ADDR_W = 4
) (
    input wire logic              clk_i,
    input wire logic              reset_n_i,
    input wire logic              source_select_hi_i,
    input wire logic              source_select_lo_i,
    input wire logic              file_enable_n_i,
    input wire logic              push_not_pop_i,
    input wire logic              incrementer_carry_in_i,
    input wire logic              latch_load_enable_n_i,
    input wire logic              force_zero_n_i,
    input wire logic              output_enable_n_i,
    input wire logic [ADDR_W-1:0] force_one_i,
    input wire logic [ADDR_W-1:0] direct_addr_i,
    input wire logic [ADDR_W-1:0] branch_latch_data_i,
    input wire logic [ADDR_W-1:0] next_addr_o,
    input wire logic              next_addr_oe_o,
    input wire logic              incrementer_carry_out_o
);
    // Pins take three edges to reach the outputs; wait until history is real
    logic [2:0] up_cnt;
    wire        up    = up_cnt == 3'h7;
    wire [1:0]  sel   = {source_select_hi_i, source_select_lo_i};
    wire        clean = force_zero_n_i && force_one_i == '0;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) up_cnt <= 3'h0;
        else if (!up) up_cnt <= up_cnt + 3'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_call;
        up && sel == 2'h3 && !file_enable_n_i && push_not_pop_i;
    endsequence
    sequence s_ret;
        sel == 2'h2 && !file_enable_n_i && !push_not_pop_i && clean;
    endsequence
    sequence s_ref;
        up && sel == 2'h2 && file_enable_n_i && clean;
    endsequence
    sequence s_load;
        up && !latch_load_enable_n_i ##1 sel == 2'h1 && clean;
    endsequence
    property p_zero;
        up && $past(!force_zero_n_i, 3) |-> next_addr_o == '0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero force lost");
    property p_or;
        up && $past(force_zero_n_i, 3) |->
            (next_addr_o & $past(force_one_i, 3)) == $past(force_one_i, 3);
    endproperty
    a_or: assert property (p_or) else $error("or force lost");
    property p_direct;
        up && $past(sel == 2'h3 && clean, 3) |->
            next_addr_o == $past(direct_addr_i, 3);
    endproperty
    a_direct: assert property (p_direct) else $error("direct wrong");
    property p_carry;
        up |-> incrementer_carry_out_o ==
            ($past(incrementer_carry_in_i, 3) && &next_addr_o);
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");
    property p_oe;
        up |-> next_addr_oe_o == !$past(output_enable_n_i, 3);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_count;
        up && $past(sel == 2'h0 && clean, 3) |-> next_addr_o ==
            $past(next_addr_o) + ADDR_W'($past(incrementer_carry_in_i, 4));
    endproperty
    a_count: assert property (p_count) else $error("count wrong");
    property p_call;
        s_call ##1 s_ret |-> ##3 next_addr_o == $past(next_addr_o, 2)
            + ADDR_W'($past(incrementer_carry_in_i, 5));
    endproperty
    a_call: assert property (p_call) else $error("return wrong");
    property p_ref;
        s_ref ##1 s_ref |-> ##3 next_addr_o == $past(next_addr_o);
    endproperty
    a_ref: assert property (p_ref) else $error("stack moved");
    property p_latch;
        s_load |-> ##3 next_addr_o == $past(branch_latch_data_i, 4);
    endproperty
    a_latch: assert property (p_latch) else $error("latch wrong");
endmodule
`default_nettype wire

// >>> bench/mps_uword_model.sv
`timescale 1ns/1ps
`default_nettype none
module mps_uword_model (
    input  wire logic [19:0] uword_i,
    output logic             sel_hi_o,
    output logic             sel_lo_o,
    output logic             file_en_n_o,
    output logic             push_o,
    output logic             carry_in_o,
    output logic             load_n_o,
    output logic             zero_n_o,
    output logic             oe_n_o,
    output logic [3:0]       or_o,
    output logic [3:0]       direct_o,
    output logic [3:0]       data_o
);
    // Microword fields drive the sequencer control pins
    assign {sel_hi_o, sel_lo_o, file_en_n_o, push_o, carry_in_o, load_n_o,
            zero_n_o, oe_n_o, or_o, direct_o, data_o} = uword_i;
endmodule
`default_nettype wire

// >>> bench/tb_mps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module tb_mps_sequencer;
    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic [19:0] uword = 20'hfffff;
    wire logic  source_select_hi_i, source_select_lo_i, file_enable_n_i;
    wire logic  push_not_pop_i, incrementer_carry_in_i, latch_load_enable_n_i;
    wire logic  force_zero_n_i, output_enable_n_i;
    wire logic [3:0] force_one_i, direct_addr_i, branch_latch_data_i;
    logic [3:0] next_addr_o;
    logic       next_addr_oe_o, incrementer_carry_out_o;
    logic [3:0] upc = 4'h0, lat = 4'h0, stk [4] = '{default: 4'h0};
    logic [1:0] ptr = 2'h0;
    logic [5:0] eq [$];
    int         checks = 0, n_fail = 0, cyc = 0;
    mps_sequencer uut (.clk_i, .reset_n_i, .source_select_hi_i,
        .source_select_lo_i, .file_enable_n_i, .push_not_pop_i,
        .incrementer_carry_in_i, .latch_load_enable_n_i, .force_zero_n_i,
        .output_enable_n_i, .force_one_i, .direct_addr_i,
        .branch_latch_data_i, .next_addr_o, .next_addr_oe_o,
        .incrementer_carry_out_o);
    mps_uword_model mw (.uword_i(uword), .sel_hi_o(source_select_hi_i),
        .sel_lo_o(source_select_lo_i), .file_en_n_o(file_enable_n_i),
        .push_o(push_not_pop_i), .carry_in_o(incrementer_carry_in_i),
        .load_n_o(latch_load_enable_n_i), .zero_n_o(force_zero_n_i),
        .oe_n_o(output_enable_n_i), .or_o(force_one_i),
        .direct_o(direct_addr_i), .data_o(branch_latch_data_i));
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 200) begin
            n_fail++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [19:0] op(logic [1:0] s, logic f, logic p,
        logic [3:0] d, logic [7:0] x);
        return {s, f, p, x, d, d};
    endfunction
    // Outputs lag the pins by three rising edges
    task automatic step(input logic [19:0] w);
        logic [3:0] y;
        logic [5:0] e;
        @(negedge clk_i);
        if (eq.size() == 3) begin
            e = eq.pop_front();
            `CHK("next_addr", e[3:0], next_addr_o)
            `CHK("addr_oe", e[5], next_addr_oe_o)
            `CHK("carry_out", e[4], incrementer_carry_out_o)
        end
        case (w[19:18])
            2'h0: y = upc;
            2'h1: y = lat;
            2'h2: y = stk[ptr];
            default: y = w[7:4];
        endcase
        y = w[13] ? (y | w[11:8]) : 4'h0;
        eq.push_back({~w[12], w[15] && y == 4'hf, y});
        if (!w[17] && w[16]) begin
            ptr = ptr + 2'h1;
            stk[ptr] = upc;
        end else if (!w[17]) begin
            ptr = ptr - 2'h1;
        end
        upc = y + 4'(w[15]);
        if (!w[14]) lat = w[3:0];
        uword = w;
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        repeat (3) step(20'hfffff);
        step(op(2'h0, 1'b1, 1'b0, 4'h0, 8'he0));
        step(op(2'h0, 1'b1, 1'b0, 4'h5, 8'ha0));
        step(op(2'h1, 1'b1, 1'b0, 4'h0, 8'he0));
        step(op(2'h3, 1'b0, 1'b1, 4'h9, 8'he0));
        step(op(2'h2, 1'b0, 1'b0, 4'h0, 8'he0));
        $display("test call_return done");
        repeat (6) step(op(2'h0, 1'b0, 1'b1, 4'h0, 8'he0));
        repeat (6) step(op(2'h2, 1'b0, 1'b0, 4'h0, 8'he0));
        step(op(2'h1, 1'b0, 1'b0, 4'h0, 8'he0));
        step(op(2'h2, 1'b0, 1'b1, 4'h0, 8'he0));
        repeat (2) step(op(2'h2, 1'b1, 1'b1, 4'h0, 8'he0));
        $display("test stack done");
        repeat (2) step(op(2'h0, 1'b1, 1'b0, 4'h0, 8'h60));
        step(op(2'h3, 1'b1, 1'b0, 4'h7, 8'hcf));
        step(op(2'h3, 1'b1, 1'b0, 4'h8, 8'he5));
        step(op(2'h3, 1'b1, 1'b0, 4'hf, 8'hf0));
        step(op(2'h3, 1'b1, 1'b0, 4'hf, 8'h60));
        step(op(2'h0, 1'b1, 1'b0, 4'h3, 8'ha0));
        step(op(2'h1, 1'b1, 1'b0, 4'h0, 8'he0));
        repeat (3) step(op(2'h0, 1'b1, 1'b0, 4'h0, 8'he0));
        $display("test output_control done");
        results();
    end
endmodule
bind mps_sequencer mps_sequencer_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk_i, .reset_n_i, .source_select_hi_i, .source_select_lo_i,
    .file_enable_n_i, .push_not_pop_i, .incrementer_carry_in_i,
    .latch_load_enable_n_i, .force_zero_n_i, .output_enable_n_i,
    .force_one_i, .direct_addr_i, .branch_latch_data_i, .next_addr_o,
    .next_addr_oe_o, .incrementer_carry_out_o);
`default_nettype wire
